// file: rtl/dcg_consts.svh
// constant header for the synthesis and sweep controller
`ifndef DCG_CONSTS_SVH
`define DCG_CONSTS_SVH
`define DCG_A_LEVEL       8'h00
`define DCG_A_FREQ_LO     8'h01
`define DCG_A_FREQ_HI     8'h02
`define DCG_A_PHASE_LO    8'h03
`define DCG_A_PHASE_HI    8'h04
`define DCG_A_START_LO    8'h05
`define DCG_A_START_HI    8'h06
`define DCG_A_STOP_LO     8'h07
`define DCG_A_STOP_HI     8'h08
`define DCG_A_INC_LO      8'h09
`define DCG_A_INC_HI      8'h0a
`define DCG_A_MODE        8'h0b
`define DCG_CORE_STRIDE   8'h10
`define DCG_ENABLE        8'h20
`define DCG_GATE          8'h21
`define DCG_STROBE_A      8'h22
`define DCG_STROBE_B      8'h23
`define DCG_STROBE_BOTH   8'h24
`define DCG_STATUS        8'h25
`define DCG_LOAD_OSC      8'h26
`define DCG_LOAD_FACTORY  8'h27
`define DCG_EN_SYNTH      3'h1
`define DCG_EN_SWEEP      3'h7
`define DCG_MODE_RAMP     0
`define DCG_MODE_RZ       1
`define DCG_MODE_REPEAT   2
`define DCG_STEP_SAMPLES  5'h10
`endif

// file: rtl/dcg_pkg.sv
// types shared by the synthesis controller files
package dcg_pkg;
  typedef enum logic [1:0] {DCG_IDLE, DCG_TONE, DCG_SWEEP, DCG_DONE}
    dcg_state_t;
  typedef struct packed {
    logic [31:0] freq;
    logic [31:0] phase;
    logic [15:0] level;
    logic [31:0] start;
    logic [31:0] stop;
    logic [31:0] inc;
  } dcg_param_t;
endpackage : dcg_pkg

// file: rtl/dcg_core_if.sv
// control bundle between the register file and one core engine
`timescale 1ns/10ps
interface dcg_core_if;
  dcg_pkg::dcg_param_t act;
  logic [2:0]          mode;
  logic [2:0]          enable;
  logic                start;
  logic                sync;
  logic                busy;
  modport ctl (output act, mode, enable, start, sync, input busy);
  modport eng (input act, mode, enable, start, sync, output busy);
endinterface : dcg_core_if

// file: rtl/dcg_core.sv
// one core engine: phase accumulator, sweep stepping and output level
`timescale 1ns/10ps
`include "dcg_consts.svh"
module dcg_core #(
  parameter int W = 16                   // sample width
) (
  input  wire logic         clk_i,       // sample clock
  input  wire logic         rst_i,       // sync reset, high
  dcg_core_if.eng           cif,         // control from register file
  input  wire logic [W-1:0] sample_i,    // normal sample input
  output logic      [W-1:0] phase_o,     // phase to mixer
  output logic      [W-1:0] amp_o        // amplitude to mixer
);
  dcg_pkg::dcg_state_t st_q;
  logic [31:0] acc_q;
  logic [31:0] fcur_q;
  logic [4:0]  cnt_q;
  logic        on;
  logic        sweep;
  assign on    = cif.enable == `DCG_EN_SYNTH || cif.enable == `DCG_EN_SWEEP;
  assign sweep = cif.enable == `DCG_EN_SWEEP;
  assign cif.busy = st_q == dcg_pkg::DCG_SWEEP;

  // mode sequencing; a new trigger relaunches the sweep from IDLE, SWEEP or DONE, but not from TONE
  always_ff @(posedge clk_i) begin
    if (rst_i || !on) begin
      st_q <= dcg_pkg::DCG_IDLE;
    end else begin
      case (st_q)
        dcg_pkg::DCG_IDLE, dcg_pkg::DCG_DONE: begin
          if (sweep && cif.start) st_q <= dcg_pkg::DCG_SWEEP;
          else if (!sweep && (cif.start || cif.sync))
            st_q <= dcg_pkg::DCG_TONE;
        end
        dcg_pkg::DCG_TONE: if (sweep) st_q <= dcg_pkg::DCG_IDLE;
        dcg_pkg::DCG_SWEEP: begin
          if (cnt_q == `DCG_STEP_SAMPLES - 5'h01 &&
              fcur_q >= cif.act.stop && !cif.start &&
              !cif.mode[`DCG_MODE_REPEAT])
            st_q <= dcg_pkg::DCG_DONE;
        end
        default: st_q <= dcg_pkg::DCG_IDLE;
      endcase
    end
  end

  // frequency stepping every sixteenth sample up to the stop word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fcur_q <= 32'h0;
      cnt_q  <= 5'h0;
    end else if (!sweep) begin
      fcur_q <= cif.act.freq;
      cnt_q  <= 5'h0;
    end else if (cif.start) begin
      fcur_q <= cif.act.start;
      cnt_q  <= 5'h0;
    end else if (st_q == dcg_pkg::DCG_SWEEP) begin
      cnt_q <= (cnt_q == `DCG_STEP_SAMPLES - 5'h01) ? 5'h0 : cnt_q + 5'h01;
      if (cnt_q == `DCG_STEP_SAMPLES - 5'h01) begin
        if (fcur_q >= cif.act.stop)
          fcur_q <= cif.mode[`DCG_MODE_REPEAT] ? cif.act.start : fcur_q;
        else
          fcur_q <= fcur_q + cif.act.inc + 32'h1;
      end
    end
  end

  // phase accumulator, restarted by sync or a fresh trigger
  always_ff @(posedge clk_i) begin
    if (rst_i || cif.sync || cif.start) begin
      acc_q <= 32'h0;
    end else if (st_q == dcg_pkg::DCG_TONE ||
                 st_q == dcg_pkg::DCG_SWEEP) begin
      acc_q <= acc_q + fcur_q;
    end
  end

  // output select: ramp, sine phase, return-to-zero or live samples
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_o <= '0;
      amp_o   <= '0;
    end else if (!on) begin
      phase_o <= '0;
      amp_o   <= sample_i;
    end else if (st_q == dcg_pkg::DCG_DONE && cif.mode[`DCG_MODE_RZ]) begin
      phase_o <= '0;
      amp_o   <= '0;
    end else if (st_q == dcg_pkg::DCG_IDLE) begin
      phase_o <= '0;
      amp_o   <= '0;
    end else begin
      phase_o <= W'((acc_q + cif.act.phase) >> (32 - W));
      // outside a sweep, ramp level follows the accumulator instead of the constant
      amp_o   <= cif.mode[`DCG_MODE_RAMP] && !sweep ?
                 W'(acc_q >> (32 - W)) : W'(cif.act.level);
    end
  end

  cov_sweep_c: cover property (@(posedge clk_i) st_q == dcg_pkg::DCG_SWEEP);
  cov_done_c: cover property (@(posedge clk_i) st_q == dcg_pkg::DCG_DONE);
  cov_tone_c: cover property (@(posedge clk_i) st_q == dcg_pkg::DCG_TONE);

  sweep_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sweep && on && cif.start |=> fcur_q == $past(cif.act.start))
    else $error("sweep did not load start word");
  step_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sweep && st_q == dcg_pkg::DCG_SWEEP && !cif.start && !$past(cif.start)
    && $changed(fcur_q) |-> $past(cnt_q) == 5'h0f)
    else $error("step outside sixteenth sample");
  sync_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cif.sync |=> acc_q == 32'h0)
    else $error("sync did not restart phase");
  input_cut_a: assert property (@(posedge clk_i) disable iff (rst_i)
    on && st_q == dcg_pkg::DCG_TONE && !cif.mode[`DCG_MODE_RAMP]
    && $stable(cif.act.level) |=> amp_o == W'($past(cif.act.level)))
    else $error("synthesis level not applied");
  rz_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    on && st_q == dcg_pkg::DCG_DONE && cif.mode[`DCG_MODE_RZ]
    |=> amp_o == '0)
    else $error("output not returned to zero");
endmodule : dcg_core

// file: rtl/dcg_top.sv
// register file and two synthesis cores of the dual converter
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/10ps
`include "dcg_consts.svh"
module dcg_top #(
  parameter int W = 16                   // sample width
) (
  input  wire logic         clk_i,       // sample clock, 50 MHz
  input  wire logic         rst_i,       // sync reset, active high
  input  wire logic [7:0]   addr_i,      // register address
  input  wire logic [15:0]  wdata_i,     // write data
  input  wire logic         wr_i,        // write strobe
  input  wire logic         rd_i,        // read strobe
  output logic      [15:0]  rdata_o,     // read data, next cycle
  input  wire logic         sync_i,      // sync pulse
  input  wire logic [W-1:0] sample_a_i,  // core a normal samples
  input  wire logic [W-1:0] sample_b_i,  // core b normal samples
  output logic      [W-1:0] phase_a_o,   // core a mixer phase
  output logic      [W-1:0] amp_a_o,     // core a mixer amplitude
  output logic      [W-1:0] phase_b_o,   // core b mixer phase
  output logic      [W-1:0] amp_b_o      // core b mixer amplitude
);
  dcg_core_if cif [2] ();
  dcg_pkg::dcg_param_t shd_q [2];
  dcg_pkg::dcg_param_t act_q [2];
  logic [2:0]  mode_q [2];
  logic [5:0]  enable_q;
  logic [1:0]  gate_q;
  logic [1:0]  strobe_q;
  logic [1:0]  launch_q;
  logic [1:0]  busy;
  logic        sync_q;

  // register index within a core block, or none
  function automatic logic [4:0] core_off(input logic [7:0] a,
                                           input logic c);
    logic [7:0] base;
    base = c ? `DCG_CORE_STRIDE : 8'h00;
    if (a >= base && a <= base + `DCG_A_MODE) core_off = 5'(a - base);
    else core_off = 5'h1f;
  endfunction : core_off

  // trigger pulses: a write to a strobe address while that core's gate_q bit is set, data ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_q <= 2'h0;
      launch_q <= 2'h0;
      sync_q   <= 1'b0;
    end else begin
      strobe_q[0] <= wr_i && gate_q[0] && (addr_i == `DCG_STROBE_A ||
                     addr_i == `DCG_STROBE_BOTH);
      strobe_q[1] <= wr_i && gate_q[1] && (addr_i == `DCG_STROBE_B ||
                     addr_i == `DCG_STROBE_BOTH);
      sync_q      <= sync_i;
      // launch lags the copy so the core starts on the new words
      launch_q    <= strobe_q;
    end
  end

  // global enables and strobe gate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= 6'h0;
      gate_q   <= 2'h0;
    end else if (wr_i && addr_i == `DCG_ENABLE) begin
      enable_q <= wdata_i[5:0];
    end else if (wr_i && addr_i == `DCG_GATE) begin
      gate_q <= wdata_i[1:0];
    end
  end

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_core
      // staged shadow words, the 32-bit ones written half by half
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          shd_q[c]  <= '0;
          mode_q[c] <= 3'h0;
        end else if (wr_i) begin
          case (core_off(addr_i, c == 1))
            5'h00: shd_q[c].level         <= wdata_i;
            5'h01: shd_q[c].freq[15:0]    <= wdata_i;
            5'h02: shd_q[c].freq[31:16]   <= wdata_i;
            5'h03: shd_q[c].phase[15:0]   <= wdata_i;
            5'h04: shd_q[c].phase[31:16]  <= wdata_i;
            5'h05: shd_q[c].start[15:0]   <= wdata_i;
            5'h06: shd_q[c].start[31:16]  <= wdata_i;
            5'h07: shd_q[c].stop[15:0]    <= wdata_i;
            5'h08: shd_q[c].stop[31:16]   <= wdata_i;
            5'h09: shd_q[c].inc[15:0]     <= wdata_i;
            5'h0a: shd_q[c].inc[31:16]    <= wdata_i;
            5'h0b: mode_q[c]              <= wdata_i[2:0];
            default: mode_q[c] <= mode_q[c];
          endcase
        end
      end

      // atomic copy on trigger or sync; values other than mode_q never apply on their own
      always_ff @(posedge clk_i) begin
        if (rst_i) act_q[c] <= '0;
        else if (strobe_q[c] || sync_q) act_q[c] <= shd_q[c];
      end

      assign cif[c].act    = act_q[c];
      assign cif[c].mode   = mode_q[c];
      assign cif[c].enable = enable_q[3*c +: 3];
      assign cif[c].start  = launch_q[c];
      assign cif[c].sync   = sync_q;
      assign busy[c]       = cif[c].busy;

      atomic_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        strobe_q[c] |=> act_q[c] == $past(shd_q[c]))
        else $error("trigger did not copy shadow");
      hold_active_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !strobe_q[c] && !sync_q |=> act_q[c] == $past(act_q[c]))
        else $error("active values changed without trigger");
    end
  endgenerate

  dcg_core #(.W(W)) u_core_a (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cif      (cif[0]),
    .sample_i (sample_a_i),
    .phase_o  (phase_a_o),
    .amp_o    (amp_a_o)
  );

  dcg_core #(.W(W)) u_core_b (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cif      (cif[1]),
    .sample_i (sample_b_i),
    .phase_o  (phase_b_o),
    .amp_o    (amp_b_o)
  );

  // read port: data stand one cycle after the strobe only
  always_ff @(posedge clk_i) begin
    if (rst_i || !rd_i) begin
      rdata_o <= 16'h0;
    end else begin
      case (addr_i)
        `DCG_ENABLE: rdata_o <= {10'h0, enable_q};
        `DCG_GATE:   rdata_o <= {14'h0, gate_q};
        `DCG_STATUS: rdata_o <= {14'h0, busy};
        `DCG_A_FREQ_LO: rdata_o <= shd_q[0].freq[15:0];
        `DCG_A_FREQ_HI: rdata_o <= shd_q[0].freq[31:16];
        `DCG_A_MODE: rdata_o <= {13'h0, mode_q[0]};
        default:     rdata_o <= 16'h0;
      endcase
    end
  end

  gate_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `DCG_STROBE_BOTH && gate_q == 2'h0
    |=> strobe_q == 2'h0)
    else $error("trigger passed a closed gate");
  pulse_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `DCG_STROBE_A && gate_q[0] |=> strobe_q[0])
    else $error("trigger write gave no pulse");
  cov_both_c: cover property (@(posedge clk_i) strobe_q == 2'h3);
  cov_sync_c: cover property (@(posedge clk_i) sync_q && enable_q != 6'h0);
endmodule : dcg_top

// file: testbench/dcg_host.sv
// partner model: register host issuing one-cycle writes and reads
`timescale 1ns/10ps
module dcg_host (
  input  wire logic        clk_i,    // sample clock
  output logic      [7:0]  addr_o,   // register address
  output logic      [15:0] wdata_o,  // write data
  output logic             wr_o,     // write strobe
  output logic             rd_o,     // read strobe
  input  wire logic [15:0] rdata_i   // read data, cycle after strobe
);
  // bus is quiet from time zero so nothing is taken during reset
  initial begin
    addr_o  = 8'h00;
    wdata_o = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // single write cycle; a whole refresh is just a short run of these
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : dcg_host

// file: testbench/tb.sv
// self-checking bench for the two-core synthesis controller
`timescale 1ns/10ps
`include "dcg_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
  logic        clk_i;
  logic        rst_i;
  logic        sync_i;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [15:0] smp_a;
  logic [15:0] smp_b;
  logic [15:0] ph_a;
  logic [15:0] am_a;
  logic [15:0] ph_b;
  logic [15:0] am_b;
  int          err_count;
  int          total_checks;

  dcg_top uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sync_i(sync_i),
    .sample_a_i(smp_a), .sample_b_i(smp_b), .phase_a_o(ph_a),
    .amp_a_o(am_a), .phase_b_o(ph_b), .amp_b_o(am_b));

  dcg_host host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .rdata_i(rdata));

  // 50 MHz sample clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic give_verdict;
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // polls status under a read limit; a hang ends the run
  task automatic wait_busy(input logic v, input int lim);
    logic [15:0] d;
    int          n;
    n = 0;
    do begin
      host.rd(`DCG_STATUS, d);
      n++;
    end while (d[0] !== v && n < lim);
    if (d[0] !== v) begin
      err_count++;
      $display("[FAIL] busy wait exp %h got %h", v, d[0]);
      give_verdict();
    end
  endtask : wait_busy

  task automatic t_reset;
    logic [15:0] d;
    `CHK("phase a idle", 16'h0000, ph_a)
    host.rd(8'h30, d);
    `CHK("unmapped read", 16'h0000, d)
  endtask : t_reset

  // staged values wait for a strobe; the gate blocks core b
  task automatic t_strobe;
    logic [15:0] p;
    logic [15:0] q;
    host.wr(`DCG_A_LEVEL, 16'h1234);
    host.wr(`DCG_A_FREQ_LO, 16'h4000);
    host.wr(`DCG_A_FREQ_HI, 16'h0100);
    host.wr(`DCG_A_LEVEL + `DCG_CORE_STRIDE, 16'h2222);
    host.wr(`DCG_A_FREQ_HI + `DCG_CORE_STRIDE, 16'h0200);
    host.wr(`DCG_ENABLE, 16'h0009);
    host.wr(`DCG_STROBE_BOTH, 16'h0000);
    host.wr(`DCG_GATE, 16'h0001);
    cyc(6);
    `CHK("level before strobe", 16'h0000, am_a)
    host.wr(`DCG_STROBE_A, 16'h0000);
    host.wr(`DCG_STROBE_B, 16'h0000);
    cyc(6);
    `CHK("core a level", 16'h1234, am_a)
    `CHK("gated core b", 16'h0000, am_b)
    host.wr(`DCG_GATE, 16'h0003);
    host.wr(`DCG_STROBE_BOTH, 16'h0000);
    cyc(6);
    `CHK("core b level", 16'h2222, am_b)
    p = ph_a;
    q = ph_b;
    cyc(4);
    `CHK("core a phase step", 16'h0401, 16'(ph_a - p))
    `CHK("core b phase step", 16'h0800, 16'(ph_b - q))
  endtask : t_strobe

  // untriggered value lands on the next sync pulse
  task automatic t_sync;
    host.wr(`DCG_A_LEVEL, 16'h0777);
    cyc(6);
    `CHK("level held", 16'h1234, am_a)
    host.wr(`DCG_LOAD_OSC, 16'h0007);
    host.wr(`DCG_LOAD_FACTORY, 16'h0000);
    @(posedge clk_i);
    sync_i <= 1'b1;
    @(posedge clk_i);
    sync_i <= 1'b0;
    cyc(6);
    `CHK("level at sync", 16'h0777, am_a)
  endtask : t_sync

  task automatic t_ramp;
    logic [15:0] s;
    host.wr(`DCG_A_MODE, 16'h0001);
    host.wr(`DCG_STROBE_A, 16'h0000);
    cyc(6);
    s = am_a;
    cyc(1);
    `CHK("ramp moves", 1'b1, am_a !== s)
  endtask : t_ramp

  // one-shot sweep 0 -> 0x300 in steps of 0x100, then return to zero
  task automatic t_sweep;
    host.wr(`DCG_A_MODE, 16'h0002);
    host.wr(`DCG_A_START_LO, 16'h0000);
    host.wr(`DCG_A_START_HI, 16'h0000);
    host.wr(`DCG_A_STOP_LO, 16'h0300);
    host.wr(`DCG_A_STOP_HI, 16'h0000);
    host.wr(`DCG_A_INC_LO, 16'h00ff);
    host.wr(`DCG_A_INC_HI, 16'h0000);
    host.wr(`DCG_ENABLE, 16'h000f);
    host.wr(`DCG_STROBE_A, 16'h0000);
    wait_busy(1'b1, 10);
    `CHK("sweep level", 16'h0777, am_a)
    wait_busy(1'b0, 60);
    cyc(3);
    `CHK("zero after sweep", 16'h0000, am_a)
    host.wr(`DCG_STROBE_A, 16'h0000);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 60);
  endtask : t_sweep

  task automatic t_repeat;
    logic [15:0] d;
    host.wr(`DCG_A_MODE, 16'h0006);
    host.wr(`DCG_STROBE_A, 16'h0000);
    wait_busy(1'b1, 10);
    cyc(200);
    host.rd(`DCG_STATUS, d);
    `CHK("sweep repeats", 1'b1, d[0])
  endtask : t_repeat

  // reset held two cycles before any register traffic
  initial begin
    err_count    = 0;
    total_checks = 0;
    rst_i        = 1'b1;
    sync_i       = 1'b0;
    smp_a        = 16'h0abc;
    smp_b        = 16'h0def;
    cyc(2);
    rst_i <= 1'b0;
    t_reset();
    t_strobe();
    t_sync();
    t_ramp();
    t_sweep();
    t_repeat();
    give_verdict();
  end
endmodule : tb
